// >>> rptx_pkg.sv
// ==================================================
// Shared types, codes and register map
package rptx_pkg;
	// One byte from the switch: parity, control flag, two nibbles
	typedef struct packed {
		logic parity;
		logic ctl;
		logic [3:0] hi;
		logic [3:0] lo;
	} rptx_byte_s;
	// One encoded symbol pair
	typedef struct packed {
		logic [4:0] hi;
		logic [4:0] lo;
	} rptx_pair_s;
	// 5B line symbols
	localparam logic [4:0] SYM_I = 5'h1f;
	localparam logic [4:0] SYM_H = 5'h04;
	localparam logic [4:0] SYM_Q = 5'h00;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0d;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_S = 5'h19;
	localparam logic [4:0] SYM_V = 5'h01;
	// Control nibble codes, sent with the control flag set
	localparam logic [3:0] CTL_Q = 4'h0;
	localparam logic [3:0] CTL_H = 4'h1;
	localparam logic [3:0] CTL_T0 = 4'h4;
	localparam logic [3:0] CTL_T1 = 4'h5;
	localparam logic [3:0] CTL_R = 4'h6;
	localparam logic [3:0] CTL_S = 4'h7;
	localparam logic [3:0] CTL_JK = 4'hd;
	localparam logic [3:0] CTL_I = 4'hf;
	// Fixed invalid-connection pattern
	localparam logic [9:0] INVALID_PATTERN = 10'h13a;
	// Transmit modes
	localparam logic [2:0] TXM_ACTIVE = 3'h0;
	localparam logic [2:0] TXM_IDLE = 3'h1;
	localparam logic [2:0] TXM_MASTER = 3'h2;
	localparam logic [2:0] TXM_QUIET = 3'h3;
	localparam logic [2:0] TXM_HALT = 3'h4;
	localparam logic [2:0] TXM_OFF = 3'h5;
	// Injection modes
	localparam logic [1:0] INJ_NONE = 2'h0;
	localparam logic [1:0] INJ_ONESHOT = 2'h1;
	localparam logic [1:0] INJ_PERIODIC = 2'h2;
	localparam logic [1:0] INJ_CONT = 2'h3;
	// Register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_TSTATE = 8'h04;
	localparam logic [7:0] OFS_SWCFG = 8'h08;
	localparam logic [7:0] OFS_THRESH = 8'h0c;
	localparam logic [7:0] OFS_SYMA = 8'h10;
	localparam logic [7:0] OFS_SYMB = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// Field positions
	localparam int BIT_PLAIN_NRZ = 6;
	localparam int BIT_PAR_EN = 6;
	localparam int POS_TXMODE = 2;
	// Reset values
	localparam logic [2:0] RST_TXMODE = 3'h5;
	localparam logic [5:0] RST_SWCFG = 6'h3f;
	// Preamble targets
	localparam logic [3:0] PRE_TARGET = 4'h7;
	localparam logic [3:0] PRE_MAX = 4'hf;
	// Index of the last bit in one ten-bit serial byte
	localparam logic [3:0] BIT_LAST = 4'h9;

	// 4B/5B encoder for one nibble
	function automatic logic [4:0] rptx_enc(input logic ctl, input logic upper,
		input logic [3:0] nib);
		logic [4:0] s;
		s = SYM_V;
		if (ctl) begin
			case (nib)
				CTL_Q: s = SYM_Q;
				CTL_H: s = SYM_H;
				CTL_T0, CTL_T1: s = SYM_T;
				CTL_R: s = SYM_R;
				CTL_S: s = SYM_S;
				CTL_JK: s = upper ? SYM_J : SYM_K;
				CTL_I: s = SYM_I;
				default: s = SYM_V;
			endcase
		end else begin
			case (nib)
				4'h0: s = 5'h1e;
				4'h1: s = 5'h09;
				4'h2: s = 5'h14;
				4'h3: s = 5'h15;
				4'h4: s = 5'h0a;
				4'h5: s = 5'h0b;
				4'h6: s = 5'h0e;
				4'h7: s = 5'h0f;
				4'h8: s = 5'h12;
				4'h9: s = 5'h13;
				4'ha: s = 5'h16;
				4'hb: s = 5'h17;
				4'hc: s = 5'h1a;
				4'hd: s = 5'h1b;
				4'he: s = 5'h1c;
				default: s = 5'h1d;
			endcase
		end
		return s;
	endfunction
endpackage

// >>> rptx_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Reset symbol 0110 encodes 00111, control flag
// - Violation in repeat sends two Halt pairs, one if Idle or JK follows
// - Idle-any enters idle, sends Idle until JK
// - JK from any state enters repeat
// - End state: R/S before T violates
// - Preambles under seven Idle pairs gain one
// - Target seven: delete above, extend below
// - Preamble count runs from Idle to JK
// - Non-active mode overrides filter and smoother
// - Each transmit mode sends its own stream
// - Reserved transmit mode sends Quiet pairs
// - Injection overrides line state and data
// - One shot injects nth byte after JK
// - Periodic injects every (n+1)th symbol pair
// - Continuous replaces every pair, threshold zero
// - Shift register loads bytes, shifts bits
// - Mode bit 6: 0 NRZI, 1 plain NRZ
// - Switch config picks among four buses
// - Invalid bus carries fixed pattern 1 0011 1010
// - Three muxes: A, B indicate and transmitter
// - Single-port variant uses B request, A indicate
module rptx_top #(
	parameter bit DUAL_PORT = 1'b1, // Zero for the single-port variant
	parameter int AW = 8 // APB address width
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rptx_pkg::rptx_byte_s a_request,
	input wire rptx_pkg::rptx_byte_s b_request,
	input wire rptx_pkg::rptx_byte_s rx_bus,
	output rptx_pkg::rptx_byte_s a_indicate,
	output rptx_pkg::rptx_byte_s b_indicate,
	output logic txd,
	output logic tx_enable,
	output logic byte_tick
);
	// ==================================================
	// Registers and state
	typedef enum {RF_IDLE, RF_REPEAT, RF_HALT, RF_END} rptx_rf_e;
	typedef enum {SM_DIRECT, SM_EXTEND} rptx_sm_e;
	logic plain_nrz_q; // Mode register bit
	logic [1:0] inj_mode_q; // Injection mode field
	logic [2:0] tx_mode_q; // Transmit mode
	logic par_en_q; // Parity check enable
	logic [5:0] swcfg_q; // Switch selects
	logic [7:0] thresh_q; // Injection threshold
	logic [4:0] sym_a_q; // Injection symbol A
	logic [4:0] sym_b_q; // Injection symbol B
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	rptx_pkg::rptx_byte_s a_ind_q;
	rptx_pkg::rptx_byte_s b_ind_q;
	rptx_pkg::rptx_byte_s tx_byte;
	rptx_rf_e rf_q;
	rptx_rf_e rf_d;
	rptx_sm_e sm_q;
	rptx_sm_e sm_d;
	rptx_pkg::rptx_pair_s slot_q; // Smoother one-pair slot
	rptx_pkg::rptx_pair_s slot_d;
	logic [3:0] pre_cnt_q; // Idle pairs seen in preamble
	logic counting_q;
	logic [7:0] inj_cnt_q;
	logic [7:0] inj_cnt_d;
	logic armed_q; // One-shot pending
	logic armed_d;
	logic [3:0] bit_cnt_q;
	logic [9:0] shreg_q;
	logic txd_q;
	logic tx_en_q;
	logic tick_q;
	logic stb; // Byte boundary
	// Combinational path
	rptx_pkg::rptx_pair_s enc_pair;
	rptx_pkg::rptx_pair_s rf_pair;
	rptx_pkg::rptx_pair_s sm_pair;
	rptx_pkg::rptx_pair_s lsg_pair;
	rptx_pkg::rptx_pair_s out_pair;
	logic par_err, is_jk, is_ix, is_viol, is_rs, is_end;
	logic sm_jk, sm_idle, fire, lsg_en, out_jk;

	// Bus source picker, used three times
	function automatic rptx_pkg::rptx_byte_s pick(input logic [1:0] sel,
		input rptx_pkg::rptx_byte_s a, input rptx_pkg::rptx_byte_s b,
		input rptx_pkg::rptx_byte_s r);
		rptx_pkg::rptx_byte_s v;
		v = rptx_pkg::INVALID_PATTERN;
		case (sel)
			2'h0: v = DUAL_PORT ? a : rptx_pkg::INVALID_PATTERN;
			2'h1: v = b;
			2'h2: v = r;
			default: v = rptx_pkg::INVALID_PATTERN;
		endcase
		return v;
	endfunction

	// Pair built from a high and a low symbol
	function automatic rptx_pkg::rptx_pair_s pr(input logic [4:0] h, input logic [4:0] l);
		return {h, l};
	endfunction

	// ==================================================
	// APB slave, one wait state per access
	wire acc = psel && penable;
	wire wr_go = acc && pwrite && pready_q;

	// Ready and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q <= acc && !pready_q;
			if (acc && !pready_q) begin
				pslverr_q <= 1'b0;
				prdata_q <= 32'h0;
				case (paddr[7:0])
					rptx_pkg::OFS_MODE: prdata_q[rptx_pkg::BIT_PLAIN_NRZ] <= plain_nrz_q;
					rptx_pkg::OFS_TSTATE: prdata_q[6:0] <= {par_en_q, 1'b0, tx_mode_q, inj_mode_q};
					rptx_pkg::OFS_SWCFG: prdata_q[5:0] <= swcfg_q;
					rptx_pkg::OFS_THRESH: prdata_q[7:0] <= thresh_q;
					rptx_pkg::OFS_SYMA: prdata_q[4:0] <= sym_a_q;
					rptx_pkg::OFS_SYMB: prdata_q[4:0] <= sym_b_q;
					rptx_pkg::OFS_STATUS: prdata_q[9:0] <= {armed_q, pre_cnt_q,
						sm_q == SM_EXTEND, rf_q == RF_END, rf_q == RF_HALT,
						rf_q == RF_REPEAT, rf_q == RF_IDLE};
					// Unmapped: error answer, zero data
					default: pslverr_q <= 1'b1;
				endcase
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Register writes at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			plain_nrz_q <= 1'b0;
			inj_mode_q <= rptx_pkg::INJ_NONE;
			tx_mode_q <= rptx_pkg::RST_TXMODE;
			par_en_q <= 1'b0;
			swcfg_q <= rptx_pkg::RST_SWCFG;
			thresh_q <= 8'h0;
			sym_a_q <= rptx_pkg::SYM_Q;
			sym_b_q <= rptx_pkg::SYM_Q;
		end else if (ce && wr_go) begin
			case (paddr[7:0])
				rptx_pkg::OFS_MODE: plain_nrz_q <= pwdata[rptx_pkg::BIT_PLAIN_NRZ];
				rptx_pkg::OFS_TSTATE: begin
					inj_mode_q <= pwdata[1:0];
					tx_mode_q <= pwdata[rptx_pkg::POS_TXMODE +: 3];
					par_en_q <= pwdata[rptx_pkg::BIT_PAR_EN];
				end
				rptx_pkg::OFS_SWCFG: swcfg_q <= pwdata[5:0];
				rptx_pkg::OFS_THRESH: thresh_q <= pwdata[7:0];
				rptx_pkg::OFS_SYMA: sym_a_q <= pwdata[4:0];
				rptx_pkg::OFS_SYMB: sym_b_q <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	// ==================================================
	// Configuration switch
	assign tx_byte = pick(swcfg_q[5:4], a_request, b_request, rx_bus);

	// Indicate outputs, refreshed every enabled clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_ind_q <= '0;
			b_ind_q <= '0;
		end else if (ce) begin
			a_ind_q <= pick(swcfg_q[1:0], a_request, b_request, rx_bus);
			// Single-port part has no B indicate pins
			b_ind_q <= DUAL_PORT ? pick(swcfg_q[3:2], a_request, b_request, rx_bus) : '0;
		end
	end

	// ==================================================
	// Encoder and classification
	always_comb begin
		enc_pair.hi = rptx_pkg::rptx_enc(tx_byte.ctl, 1'b1, tx_byte.hi);
		enc_pair.lo = rptx_pkg::rptx_enc(tx_byte.ctl, 1'b0, tx_byte.lo);
		// Odd parity over all ten bits, parity bit included
		par_err = par_en_q && !(^tx_byte);
		is_jk = enc_pair.hi == rptx_pkg::SYM_J && enc_pair.lo == rptx_pkg::SYM_K;
		is_ix = enc_pair.hi == rptx_pkg::SYM_I;
		is_viol = par_err || enc_pair.hi == rptx_pkg::SYM_V || enc_pair.lo == rptx_pkg::SYM_V
			|| (enc_pair.hi == rptx_pkg::SYM_J) != (enc_pair.lo == rptx_pkg::SYM_K);
		is_rs = enc_pair.hi == rptx_pkg::SYM_R || enc_pair.hi == rptx_pkg::SYM_S;
		is_end = enc_pair.hi == rptx_pkg::SYM_T || enc_pair.lo == rptx_pkg::SYM_T;
	end

	// ==================================================
	// Repeat filter
	always_comb begin
		rf_d = rf_q;
		rf_pair = enc_pair;
		if (is_jk) begin
			rf_d = RF_REPEAT;
		end else begin
			case (rf_q)
				RF_IDLE: begin
					// Idle until a frame starts
					rf_pair = pr(rptx_pkg::SYM_I, rptx_pkg::SYM_I);
				end
				RF_REPEAT, RF_END: begin
					if (is_viol || (rf_q == RF_REPEAT && is_rs)) begin
						// R or S ahead of T inside a frame is bad
						rf_d = RF_HALT;
						rf_pair = pr(rptx_pkg::SYM_H, rptx_pkg::SYM_H);
					end else if (is_ix) begin
						rf_d = RF_IDLE;
						rf_pair = pr(rptx_pkg::SYM_I, rptx_pkg::SYM_I);
					end else if (is_end) begin
						rf_d = RF_END;
					end
				end
				RF_HALT: begin
					// Second Halt pair, unless Idle cuts it short
					if (is_ix) begin
						rf_pair = pr(rptx_pkg::SYM_I, rptx_pkg::SYM_I);
					end else begin
						rf_pair = pr(rptx_pkg::SYM_H, rptx_pkg::SYM_H);
					end
					rf_d = RF_IDLE;
				end
				default: rf_d = RF_IDLE;
			endcase
		end
	end

	// ==================================================
	// Smoother: one-pair slot lets it insert or drop
	always_comb begin
		sm_jk = rf_pair.hi == rptx_pkg::SYM_J && rf_pair.lo == rptx_pkg::SYM_K;
		sm_idle = rf_pair.hi == rptx_pkg::SYM_I && rf_pair.lo == rptx_pkg::SYM_I;
		sm_d = sm_q;
		slot_d = slot_q;
		sm_pair = rf_pair;
		case (sm_q)
			SM_DIRECT: begin
				if (sm_jk && counting_q && pre_cnt_q < rptx_pkg::PRE_TARGET) begin
					// Short preamble: add one Idle pair, delay the JK
					sm_pair = pr(rptx_pkg::SYM_I, rptx_pkg::SYM_I);
					slot_d = rf_pair;
					sm_d = SM_EXTEND;
				end
			end
			SM_EXTEND: begin
				sm_pair = slot_q;
				if (sm_idle && counting_q && pre_cnt_q >= rptx_pkg::PRE_TARGET) begin
					// Long preamble: drop this Idle pair, catch up
					sm_d = SM_DIRECT;
				end else begin
					slot_d = rf_pair;
				end
			end
			default: sm_d = SM_DIRECT;
		endcase
	end

	// ==================================================
	// Line state generator and injection
	always_comb begin
		lsg_en = 1'b1;
		case (tx_mode_q)
			rptx_pkg::TXM_ACTIVE: lsg_pair = sm_pair;
			rptx_pkg::TXM_IDLE: lsg_pair = pr(rptx_pkg::SYM_I, rptx_pkg::SYM_I);
			rptx_pkg::TXM_MASTER: lsg_pair = pr(rptx_pkg::SYM_H, rptx_pkg::SYM_Q);
			rptx_pkg::TXM_QUIET: lsg_pair = pr(rptx_pkg::SYM_Q, rptx_pkg::SYM_Q);
			rptx_pkg::TXM_HALT: lsg_pair = pr(rptx_pkg::SYM_H, rptx_pkg::SYM_H);
			rptx_pkg::TXM_OFF: begin
				lsg_pair = pr(rptx_pkg::SYM_Q, rptx_pkg::SYM_Q);
				lsg_en = 1'b0;
			end
			// Reserved codes fall back to Quiet
			default: lsg_pair = pr(rptx_pkg::SYM_Q, rptx_pkg::SYM_Q);
		endcase
		// Count from the JK really sent, so an extended preamble moves it too
		out_jk = lsg_pair.hi == rptx_pkg::SYM_J && lsg_pair.lo == rptx_pkg::SYM_K;
		inj_cnt_d = out_jk ? 8'h0 : inj_cnt_q + 8'h1;
		armed_d = armed_q;
		fire = 1'b0;
		case (inj_mode_q)
			rptx_pkg::INJ_ONESHOT: begin
				fire = armed_q && !out_jk && (inj_cnt_q + 8'h1) == thresh_q;
				armed_d = out_jk ? 1'b1 : (fire ? 1'b0 : armed_q);
			end
			rptx_pkg::INJ_PERIODIC: begin
				// At or past n, so a lowered threshold never waits for a wrap
				fire = inj_cnt_q >= thresh_q;
				inj_cnt_d = fire ? 8'h0 : inj_cnt_q + 8'h1;
			end
			rptx_pkg::INJ_CONT: fire = 1'b1;
			default: armed_d = 1'b0;
		endcase
		// Injection outranks line state and data
		out_pair = fire ? pr(sym_a_q, sym_b_q) : lsg_pair;
	end

	// Pipeline state, stepped once per byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf_q <= RF_IDLE;
			sm_q <= SM_DIRECT;
			slot_q <= '0;
			inj_cnt_q <= 8'h0;
			armed_q <= 1'b0;
		end else if (ce && stb) begin
			rf_q <= rf_d;
			sm_q <= sm_d;
			slot_q <= slot_d;
			inj_cnt_q <= inj_cnt_d;
			armed_q <= armed_d;
		end
	end

	// Preamble counter: start on Idle, stop on JK
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_q <= 4'h0;
			counting_q <= 1'b0;
		end else if (ce && stb) begin
			if (sm_jk) begin
				counting_q <= 1'b0;
			end else if (sm_idle) begin
				counting_q <= 1'b1;
				if (!counting_q) begin
					pre_cnt_q <= 4'h1;
				end else if (pre_cnt_q != rptx_pkg::PRE_MAX) begin
					pre_cnt_q <= pre_cnt_q + 4'h1;
				end
			end
		end
	end

	// ==================================================
	// Serializer; the byte tick stands for the byte clock
	assign stb = bit_cnt_q == rptx_pkg::BIT_LAST;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_q <= 4'h0;
			shreg_q <= '0;
			tx_en_q <= 1'b0;
			tick_q <= 1'b0;
		end else if (ce) begin
			tick_q <= stb;
			if (stb) begin
				bit_cnt_q <= 4'h0;
				shreg_q <= out_pair;
				tx_en_q <= lsg_en;
			end else begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
				shreg_q <= {shreg_q[8:0], 1'b0};
			end
		end
	end

	// Line coder: a one flips the line unless NRZ chosen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_q <= 1'b0;
		end else if (ce) begin
			txd_q <= plain_nrz_q ? shreg_q[9] : (txd_q ^ shreg_q[9]);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign a_indicate = a_ind_q;
	assign b_indicate = b_ind_q;
	assign txd = txd_q;
	assign tx_enable = tx_en_q;
	assign byte_tick = tick_q;

	// ==================================================
	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_step;
		ce && stb;
	endsequence

	property p_jk_repeat;
		s_step and is_jk |=> rf_q == RF_REPEAT;
	endproperty
	a_jk_repeat: assert property (p_jk_repeat) else $error("JK did not enter repeat");

	property p_viol_halt;
		s_step and rf_q == RF_REPEAT && is_viol && !is_jk |=> rf_q == RF_HALT;
	endproperty
	a_viol_halt: assert property (p_viol_halt) else $error("violation missed halt");

	property p_idle_hold;
		s_step and rf_q == RF_IDLE && !is_jk |=> rf_q == RF_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle state left early");

	property p_extend;
		s_step and sm_q == SM_DIRECT && sm_jk && counting_q && pre_cnt_q < rptx_pkg::PRE_TARGET
			|=> sm_q == SM_EXTEND;
	endproperty
	a_extend: assert property (p_extend) else $error("short preamble not extended");

	property p_off;
		s_step and tx_mode_q == rptx_pkg::TXM_OFF |=> !tx_enable;
	endproperty
	a_off: assert property (p_off) else $error("off mode left transmitter on");

	property p_cont;
		s_step and inj_mode_q == rptx_pkg::INJ_CONT |=> shreg_q == {sym_a_q, sym_b_q};
	endproperty
	a_cont: assert property (p_cont) else $error("continuous injection missing");

	property p_invalid;
		ce && swcfg_q[1:0] == 2'h3 |=> a_indicate == rptx_pkg::INVALID_PATTERN;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid pattern wrong");

	property p_nrzi;
		ce && !plain_nrz_q && shreg_q[9] |=> txd != $past(txd);
	endproperty
	a_nrzi: assert property (p_nrzi) else $error("NRZI one without transition");

	property p_idle_mode;
		s_step and tx_mode_q == rptx_pkg::TXM_IDLE && inj_mode_q == rptx_pkg::INJ_NONE
			|=> shreg_q == {rptx_pkg::SYM_I, rptx_pkg::SYM_I} ##1 shreg_q[9:1] == {
			rptx_pkg::SYM_I[3:0], rptx_pkg::SYM_I};
	endproperty
	a_idle_mode: assert property (p_idle_mode) else $error("idle mode not sent");
endmodule

// >>> rptx_mac_model.sv
`timescale 1ns/10ps
// ==========
// Byte source in the place of the MAC on the A request bus
module rptx_mac_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic byte_tick,
	output rptx_pkg::rptx_byte_s req
);
	rptx_pkg::rptx_byte_s pend[$]; // Bytes waiting to go out
	// Odd parity over all ten bits, so parity faults never reach the filter
	function automatic rptx_pkg::rptx_byte_s mk(input logic c, input logic [7:0] d);
		rptx_pkg::rptx_byte_s b;
		b = {1'b0, c, d};
		b.parity = ~^{c, d};
		return b;
	endfunction
	// Bench queues one byte, control flag first
	task automatic send(input logic c, input logic [7:0] d);
		pend.push_back(mk(c, d));
	endtask
	// Step after each load; Idle pairs fill the gaps like a quiet MAC
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req <= mk(1'b1, 8'hff);
		end else if (byte_tick) begin
			req <= (pend.size() > 0) ? pend.pop_front() : mk(1'b1, 8'hff);
		end
	end
endmodule

// >>> test_ring_phy_transmit_path.sv
`timescale 1ns/10ps
// ==========
// Bench for the transmit path and switch
module test_ring_phy_transmit_path;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, txd, tx_enable, byte_tick;
	logic [7:0] paddr; // Byte address
	logic [31:0] pwdata, prdata, rd; // Bus data and last read
	logic er; // Last error response
	rptx_pkg::rptx_byte_s a_request, b_request, rx_bus, a_indicate, b_indicate;
	logic [9:0] sh, w, q[$]; // Serial words, first bit in the MSB
	logic [9:0] mexp[8] = '{10'h000, 10'h3ff, 10'h080, 10'h000, 10'h084, 10'h000, 10'h000, 10'h000};
	int num_errors, total_checks, cyc, bc;
	// ==========
	// Clock, 25 ns period
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	rptx_top #(.DUAL_PORT(1'b1), .AW(8)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .a_request(a_request),
		.b_request(b_request), .rx_bus(rx_bus), .a_indicate(a_indicate),
		.b_indicate(b_indicate), .txd(txd), .tx_enable(tx_enable), .byte_tick(byte_tick));
	rptx_mac_model mac (.pclk(pclk), .presetn(presetn), .byte_tick(byte_tick), .req(a_request));
	// ==========
	// Serial monitor: the bit after each tick opens a ten-bit word
	always @(negedge pclk) begin
		if (bc > 0) begin
			sh = {sh[8:0], txd};
			bc++;
		end
		if (bc == 11) begin
			q.push_back(sh);
			bc = 0;
		end
		// Tick cycle still shows the last bit of the word before
		if (byte_tick === 1'b1) begin
			bc = 1;
		end
	end
	// Hang guard, far above the thousand or so cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			$display("BAD %0t timeout %h %h", $time, cyc, 0);
			end_of_test();
		end
	end
	// ==========
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look between edges; the next rising edge completes the transfer
		@(negedge pclk);
		while (pready !== 1'b1) begin
			@(negedge pclk);
		end
		rd = prdata;
		er = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wait for fresh words so older settings have drained
	task automatic grab(input int cnt);
		int n;
		n = 0;
		q.delete();
		while (q.size() < cnt && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		w = (q.size() > 0) ? q[q.size()-1] : 10'h2bd;
	endtask
	// JK, two data, violation, two cut data, four Idle, JK and data in one burst
	task automatic frame(input logic [9:0] first);
		int k, run;
		grab(8);
		mac.send(1'b1, 8'hdd);
		mac.send(1'b0, 8'h5a);
		mac.send(1'b0, 8'h3c);
		mac.send(1'b1, 8'h22);
		mac.send(1'b0, 8'h00);
		mac.send(1'b0, 8'h11);
		repeat (4) mac.send(1'b1, 8'hff);
		mac.send(1'b1, 8'hdd);
		mac.send(1'b0, 8'h5a);
		// Keep the idle words ahead of the first JK in the queue
		while (q.size() < 28) begin
			@(posedge pclk);
		end
		k = -1;
		foreach (q[i]) if (k < 0 && q[i] === 10'h311) k = i;
		chk(k >= 7, 1);
		if (k < 7) k = 7;
		// Five Idle pairs come in, the smoother must add a sixth
		run = 0;
		for (int i = k + 5; i < q.size() && q[i] === 10'h3ff; i++) run++;
		chk(run, 6);
		chk(q[k+1], first);
		chk(q[k+2], 10'h2ba);
		chk(q[k+3], 10'h084);
		chk(q[k+4], 10'h084);
		chk(q[k+5], 10'h3ff);
		chk(q[k+6], 10'h3ff);
		chk(q[k+11], 10'h311);
		chk(q[k+12], first);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		b_request = 10'h2a5;
		rx_bus = 10'h15a;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk(a_indicate, rptx_pkg::INVALID_PATTERN);
		chk(tx_enable, 0);
		apb(1'b0, rptx_pkg::OFS_SWCFG, 0);
		chk(rd, 32'h3f);
		apb(1'b0, rptx_pkg::OFS_TSTATE, 0);
		chk(rd, 32'h14);
		apb(1'b0, 8'h1c, 0);
		chk({rd[30:0], er}, 1);
		$display("test reset done");
		// Every source code on both indicate muxes
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, rptx_pkg::OFS_SWCFG, 32'(s * 21));
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			w = (s == 0) ? a_request : (s == 1) ? b_request : (s == 2) ? rx_bus : 10'h13a;
			chk(a_indicate, w);
			chk(b_indicate, w);
		end
		$display("test switch done");
		// Plain NRZ so each word reads straight off the line
		apb(1'b1, rptx_pkg::OFS_SWCFG, 32'h0);
		apb(1'b1, rptx_pkg::OFS_MODE, 32'h40);
		for (int m = 1; m < 8; m++) begin
			apb(1'b1, rptx_pkg::OFS_TSTATE, 32'(m * 4));
			grab(3);
			chk(w, mexp[m]);
			chk(tx_enable, m != 5);
		end
		$display("test modes done");
		// Continuous, then periodic at zero, both over Idle mode
		apb(1'b1, rptx_pkg::OFS_SYMA, 32'h0a);
		apb(1'b1, rptx_pkg::OFS_SYMB, 32'h15);
		apb(1'b1, rptx_pkg::OFS_TSTATE, 32'h07);
		grab(3);
		chk(w, 10'h155);
		apb(1'b1, rptx_pkg::OFS_TSTATE, 32'h06);
		grab(3);
		chk(w, 10'h155);
		// NRZI of all-ones Idle toggles on every bit
		apb(1'b1, rptx_pkg::OFS_TSTATE, 32'h04);
		apb(1'b1, rptx_pkg::OFS_MODE, 32'h0);
		grab(3);
		chk(w[9:1] ^ w[8:0], 9'h1ff);
		$display("test inject done");
		// Frames in active mode, plain then one shot at the first pair
		apb(1'b1, rptx_pkg::OFS_MODE, 32'h40);
		apb(1'b1, rptx_pkg::OFS_TSTATE, 32'h0);
		frame(10'h176);
		apb(1'b1, rptx_pkg::OFS_THRESH, 32'h1);
		apb(1'b1, rptx_pkg::OFS_TSTATE, 32'h1);
		frame(10'h155);
		$display("test frame done");
		end_of_test();
	end
endmodule
